// file: can_bus_node.sv
/* Other nodes on the bus, reduced to the wired line they share.
   Assumes the bench raises othDom to make a node pull the line dominant. */
`timescale 1ns/1ns
module can_bus_node (
  input wire txBit,
  input wire othDom,
  output wire rxBit
);
  // Dominant wins; a readback differs only when another node pulls low
  assign rxBit = txBit & ~othDom;
endmodule

// file: can_fault_confine.v
/*
  Error detection, fault confinement and event flag logic of a CAN
  controller, with an AHB-Lite register slave.
  Assumes a protocol engine beside it that supplies one sample strobe per
  bit with frame field qualifiers, and a single AHB master.
*/
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
`include "can_fault_regs.vh"

module can_fault_confine #(
  parameter CRC_WIDTH = 15
) (
  ref_clk,
  rst,
  ce,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hrdata,
  hreadyout,
  hresp,
  bitValid,
  txBit,
  rxBit,
  isTransmitter,
  inArbitration,
  inAckSlot,
  inFixedForm,
  inLastEofBit,
  inStuffedField,
  sendingPassiveErr,
  crcDataBit,
  crcFieldBit,
  crcCompare,
  txSuccess,
  rxSuccess,
  busOffRecover,
  txDone,
  txDoneBuf,
  rxStore,
  rxStoreBuf,
  fifoNextToLastFull,
  bus_receive_pin,
  errFrameActive,
  errFramePassive,
  retransmitReq,
  errorState
);
  input wire ref_clk;
  input wire rst;
  input wire ce;
  input wire hsel;
  input wire [31:0] haddr;
  input wire [1:0] htrans;
  input wire hwrite;
  input wire [2:0] hsize;
  input wire [31:0] hwdata;
  input wire hready;
  output reg [31:0] hrdata;
  output reg hreadyout;
  output reg hresp;
  input wire bitValid;
  input wire txBit;
  input wire rxBit;
  input wire isTransmitter;
  input wire inArbitration;
  input wire inAckSlot;
  input wire inFixedForm;
  input wire inLastEofBit;
  input wire inStuffedField;
  input wire sendingPassiveErr;
  input wire crcDataBit;
  input wire crcFieldBit;
  input wire crcCompare;
  input wire txSuccess;
  input wire rxSuccess;
  input wire busOffRecover;
  input wire txDone;
  input wire [2:0] txDoneBuf;
  input wire rxStore;
  input wire [4:0] rxStoreBuf;
  input wire fifoNextToLastFull;
  input wire bus_receive_pin;
  output reg errFrameActive;
  output reg errFramePassive;
  output reg retransmitReq;
  output reg [1:0] errorState;

  // ************************************************************
  // Bus-level error detection
  // ************************************************************
  reg [2:0] stuffCnt_q;
  reg stuffLast_q;
  reg [CRC_WIDTH-1:0] crcCalc_q;
  reg [CRC_WIDTH-1:0] crcRecv_q;
  wire excuseBit;
  wire bitErr;
  wire ackErr;
  wire formErr;
  wire stuffErr;
  wire crcErr;
  wire anyErr;
  wire crcFeed;

  // Recessive is 1; a dominant readback on a recessive bit may be legal
  assign excuseBit = txBit && !rxBit &&
    (inArbitration || inAckSlot || sendingPassiveErr);
  assign bitErr = bitValid && isTransmitter && (txBit != rxBit) &&
    !excuseBit && !inAckSlot;
  assign ackErr = bitValid && isTransmitter && inAckSlot && rxBit;
  assign formErr = bitValid && inFixedForm && !rxBit &&
    !(!isTransmitter && inLastEofBit);
  assign stuffErr = bitValid && inStuffedField && (rxBit == stuffLast_q) &&
    (stuffCnt_q == 3'h5);
  assign crcErr = crcCompare && !isTransmitter && (crcCalc_q != crcRecv_q);
  assign anyErr = bitErr || ackErr || formErr || stuffErr || crcErr;
  assign crcFeed = rxBit ^ crcCalc_q[CRC_WIDTH-1];

  always @(posedge ref_clk) begin
    if (rst) begin
      stuffCnt_q <= 3'h0;
      stuffLast_q <= 1'b1;
      crcCalc_q <= {CRC_WIDTH{1'b0}};
      crcRecv_q <= {CRC_WIDTH{1'b0}};
    end else if (ce) begin
      if (bitValid && !inStuffedField) begin
        stuffCnt_q <= 3'h0;
      end else if (bitValid) begin
        // Run length of equal bits; a stuffed-field bit run restarts on change
        stuffLast_q <= rxBit;
        if (rxBit == stuffLast_q && stuffCnt_q != 3'h0) begin
          stuffCnt_q <= (stuffCnt_q == 3'h5) ? 3'h5 : stuffCnt_q + 3'h1;
        end else begin
          stuffCnt_q <= 3'h1;
        end
      end
      if (crcDataBit && bitValid) begin
        crcCalc_q <= {crcCalc_q[CRC_WIDTH-2:0], 1'b0} ^
          (crcFeed ? `CRC_POLY : {CRC_WIDTH{1'b0}});
      end
      if (crcFieldBit && bitValid) begin
        crcRecv_q <= {crcRecv_q[CRC_WIDTH-2:0], rxBit};
      end
      if (crcCompare) begin
        // A new frame starts its CRC from zero
        crcCalc_q <= {CRC_WIDTH{1'b0}};
        crcRecv_q <= {CRC_WIDTH{1'b0}};
      end
    end
  end

  // ************************************************************
  // Error counters and confinement state
  // ************************************************************
  reg [8:0] tec_q;
  reg [7:0] rec_q;
  reg [8:0] tecNext;
  reg [7:0] recNext;
  wire busOff;
  wire passive;

  assign busOff = tec_q >= `LIM_BUSOFF;
  assign passive = (tec_q >= `LIM_PASSIVE_STATE) ||
    ({1'b0, rec_q} >= `LIM_PASSIVE_STATE);

  always @* begin
    tecNext = tec_q;
    recNext = rec_q;
    if (busOffRecover && busOff) begin
      tecNext = 9'h000;
      recNext = 8'h00;
    end else if (!busOff) begin
      // Transmitter faults weigh eight times a listener's fault
      if (anyErr && isTransmitter && !(ackErr && passive)) begin
        tecNext = (tec_q > 9'h1FF - `TEC_STEP) ? 9'h1FF : tec_q + `TEC_STEP;
      end else if (txSuccess && tec_q != 9'h000) begin
        tecNext = tec_q - 9'h001;
      end
      if (anyErr && !isTransmitter && rec_q != 8'hFF) begin
        recNext = rec_q + 8'h01;
      end else if (rxSuccess) begin
        if (rec_q > 8'h7F) begin
          recNext = `REC_RELOAD;
        end else if (rec_q != 8'h00) begin
          recNext = rec_q - 8'h01;
        end
      end
    end
  end

  // ************************************************************
  // Confinement status flags
  // ************************************************************
  reg [13:8] status_q, statusNext;
  reg [1:0] stateNext;
  wire errEntry;

  // Flags follow the counters' next values so they line up with them
  always @* begin
    statusNext = status_q;
    statusNext[`FLG_TX_BUSOFF] = tecNext >= `LIM_BUSOFF;
    statusNext[`FLG_TX_PASSIVE] = (tecNext >= `LIM_PASSIVE_FLAG) &&
      (tecNext < `LIM_BUSOFF);
    statusNext[`FLG_RX_PASSIVE] = {1'b0, recNext} >= `LIM_PASSIVE_FLAG;
    statusNext[`FLG_TX_WARN] = (tecNext >= `LIM_WARN) && (tecNext <= `LIM_WARN_TOP);
    // The receive warning lets go only below the lower limit
    if ({1'b0, recNext} < `LIM_WARN) begin
      statusNext[`FLG_RX_WARN] = 1'b0;
    end else if ({1'b0, recNext} <= `LIM_WARN_TOP) begin
      statusNext[`FLG_RX_WARN] = 1'b1;
    end
    statusNext[`FLG_COMB_WARN] = (tecNext >= `LIM_WARN) ||
      ({1'b0, recNext} >= `LIM_WARN);
    if (tecNext >= `LIM_BUSOFF) begin
      stateNext = `ST_BUSOFF;
    end else if ((tecNext >= `LIM_PASSIVE_STATE) ||
        ({1'b0, recNext} >= `LIM_PASSIVE_STATE)) begin
      stateNext = `ST_PASSIVE;
    end else begin
      stateNext = `ST_ACTIVE;
    end
  end

  // Error event fires on entry to any of the five confinement sources
  assign errEntry = |(statusNext[13:9] & ~status_q[13:9]);

  // ************************************************************
  // Event flags, buffer bits, priority code and register slave
  // ************************************************************
  localparam NUM_RX_BUF = 32;
  reg [7:0] evFlags_q, enable_q, pending;
  reg [31:0] bufFull_q, bufOvf_q, readWord;
  reg [2:0] txCode_q;
  reg [4:0] rxCode_q, ovfCode_q;
  reg [7:0] wrAddr_q, rdAddr_q;
  reg [6:0] codeNow;
  reg sleep_q, pinLast_q, dataWrite_q, readPend_q;
  wire [31:0] storeSel;
  wire [7:0] evSet, evKeep;
  wire addrPhase, targetFull, wakeSet;
  wire flagWrite, enableWrite, controlWrite, fullWrite, ovfWrite;
  genvar gi;
  assign addrPhase = hsel && htrans[1] && hready;
  assign flagWrite = dataWrite_q && (wrAddr_q == `OFS_EVENT_FLAGS);
  assign enableWrite = dataWrite_q && (wrAddr_q == `OFS_EVENT_ENABLE);
  assign controlWrite = dataWrite_q && (wrAddr_q == `OFS_CONTROL);
  assign fullWrite = dataWrite_q && (wrAddr_q == `OFS_BUF_FULL);
  assign ovfWrite = dataWrite_q && (wrAddr_q == `OFS_BUF_OVERFLOW);
  assign storeSel = {31'h00000000, rxStore} << rxStoreBuf;
  assign targetFull = bufFull_q[rxStoreBuf];
  // Idle bus is recessive; the first dominant level in sleep is activity
  assign wakeSet = sleep_q && pinLast_q && !bus_receive_pin;
  assign evSet = {anyErr, wakeSet, errEntry, 1'b0, fifoNextToLastFull,
    rxStore && targetFull, rxStore && !targetFull, txDone};
  // Software clears by writing zero; bits written one are left alone
  assign evKeep = flagWrite ? (hwdata[7:0] | ~`EVENT_MASK) : 8'hFF;

  always @* begin
    pending = evFlags_q & enable_q;
    if (pending[`FLG_TXBUF]) begin
      codeNow = {4'h0, txCode_q};
    end else if (pending[`FLG_RXBUF]) begin
      codeNow = {2'h0, rxCode_q};
    end else if (pending[`FLG_OVF]) begin
      codeNow = `CODE_OVF_BASE | {2'h0, ovfCode_q};
    end else if (pending[`FLG_FIFO]) begin
      codeNow = `CODE_FIFO;
    end else if (pending[`FLG_ERR]) begin
      codeNow = `CODE_ERROR;
    end else if (pending[`FLG_WAKE]) begin
      codeNow = `CODE_WAKE;
    end else if (pending[`FLG_INVALID]) begin
      codeNow = `CODE_INVALID;
    end else begin
      codeNow = `CODE_NONE;
    end
  end

  generate
    for (gi = 0; gi < NUM_RX_BUF; gi = gi + 1) begin : g_rxbuf
      always @(posedge ref_clk) begin
        if (rst) begin
          bufFull_q[gi] <= 1'b0;
          bufOvf_q[gi] <= 1'b0;
        end else if (ce) begin
          // A store into this buffer wins over a clear in the same cycle
          bufFull_q[gi] <= storeSel[gi] ||
            (bufFull_q[gi] && !(fullWrite && !hwdata[gi]));
          bufOvf_q[gi] <= (storeSel[gi] && bufFull_q[gi]) ||
            (bufOvf_q[gi] && !(ovfWrite && !hwdata[gi]));
        end
      end
    end
  endgenerate

  always @* begin
    case (rdAddr_q)
      `OFS_ERR_COUNTERS: readWord = {16'h0000, tec_q[7:0], rec_q};
      `OFS_EVENT_FLAGS: readWord = {16'h0000, 2'b00, status_q, evFlags_q};
      `OFS_EVENT_ENABLE: readWord = {24'h000000, enable_q};
      `OFS_EVENT_CODE: readWord = {25'h0000000, codeNow};
      `OFS_CONTROL: readWord = {31'h00000000, sleep_q};
      `OFS_BUF_FULL: readWord = bufFull_q;
      `OFS_BUF_OVERFLOW: readWord = bufOvf_q;
      default: readWord = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      tec_q <= 9'h000;
      rec_q <= 8'h00;
      status_q <= 6'h00;
      errorState <= `ST_ACTIVE;
      errFrameActive <= 1'b0;
      errFramePassive <= 1'b0;
      retransmitReq <= 1'b0;
      evFlags_q <= 8'h00;
      enable_q <= 8'h00;
      txCode_q <= 3'h0;
      rxCode_q <= 5'h00;
      ovfCode_q <= 5'h00;
      sleep_q <= 1'b0;
      pinLast_q <= 1'b1;
      dataWrite_q <= 1'b0;
      readPend_q <= 1'b0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      tec_q <= tecNext;
      rec_q <= recNext;
      status_q <= statusNext;
      errorState <= stateNext;
      // Frame kind follows the state the error was found in
      errFrameActive <= anyErr && (errorState == `ST_ACTIVE);
      errFramePassive <= anyErr && (errorState == `ST_PASSIVE);
      retransmitReq <= ackErr;
      evFlags_q <= ((evFlags_q & evKeep) | evSet) & `EVENT_MASK;
      if (txDone) txCode_q <= txDoneBuf;
      if (rxStore && !targetFull) rxCode_q <= rxStoreBuf;
      if (rxStore && targetFull) ovfCode_q <= rxStoreBuf;
      if (enableWrite) enable_q <= hwdata[7:0];
      if (controlWrite) sleep_q <= hwdata[0];
      pinLast_q <= bus_receive_pin;
      // Writes land in their data phase; reads take one wait state so that
      // a write just before them is already visible
      dataWrite_q <= addrPhase && hwrite;
      if (addrPhase) begin
        wrAddr_q <= haddr[7:0];
        rdAddr_q <= haddr[7:0];
      end
      if (addrPhase && !hwrite) begin
        readPend_q <= 1'b1;
        hreadyout <= 1'b0;
      end else if (readPend_q) begin
        readPend_q <= 1'b0;
        hrdata <= readWord;
        hreadyout <= 1'b1;
      end
    end
  end
endmodule

// file: can_fault_confine_checker.sv
/* Checker of error frames, retransmit and reset state of the block.
   Assumes a bind to can_fault_confine; recessive is 1. */
`timescale 1ns/1ns
`include "can_fault_regs.vh"
module can_fault_confine_checker (
  input wire ref_clk,
  input wire rst,
  input wire bitValid,
  input wire txBit,
  input wire rxBit,
  input wire isTransmitter,
  input wire inArbitration,
  input wire inAckSlot,
  input wire inFixedForm,
  input wire inLastEofBit,
  input wire sendingPassiveErr,
  input wire errFrameActive,
  input wire errFramePassive,
  input wire retransmitReq,
  input wire [1:0] errorState
);
  // ****************
  // Properties
  // ****************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Only the excused cases and bits sent dominant are left out, so a missed exception shows up
  sequence txMiss;
    bitValid && isTransmitter && txBit && !rxBit && !inArbitration && !inAckSlot
      && !sendingPassiveErr;
  endsequence
  busoff_silent_a: assert property (
    errorState == `ST_BUSOFF |=> !errFrameActive && !errFramePassive)
    else $error("Error frame sent while bus-off");
  bit_active_a: assert property (
    txMiss ##0 errorState == `ST_ACTIVE |-> ##[1:3] errFrameActive)
    else $error("Bit error without active error frame");
  bit_passive_a: assert property (
    txMiss ##0 errorState == `ST_PASSIVE |-> ##[1:3] errFramePassive)
    else $error("Bit error without passive error frame");
  arb_excuse_a: assert property (
    bitValid && txBit && !rxBit && (inArbitration || sendingPassiveErr) && !errFrameActive
      |=> !errFrameActive)
    else $error("Excused dominant read raised an error frame");
  ack_error_a: assert property (
    bitValid && isTransmitter && inAckSlot && rxBit |-> ##[1:3] retransmitReq)
    else $error("Missing acknowledge without retransmit");
  form_error_a: assert property (
    bitValid && inFixedForm && !inLastEofBit && !rxBit && errorState == `ST_ACTIVE
      |-> ##[1:3] errFrameActive)
    else $error("Illegal fixed-form bit without error frame");
  eof_excuse_a: assert property (
    bitValid && inLastEofBit && !isTransmitter && !rxBit && !errFrameActive |=> !errFrameActive)
    else $error("Dominant last end-of-frame bit raised an error frame");
  reset_state_a: assert property (disable iff (1'b0) rst |=> errorState == `ST_ACTIVE)
    else $error("State not error-active after reset");
endmodule
bind can_fault_confine can_fault_confine_checker i_chk (.*);

// file: can_fault_regs.vh
/*
  Constants for the CAN error confinement and event block: register
  offsets, flag bit positions, counter thresholds and event codes.
  Assumes it is included by the design, its checker and its bench.
*/
`ifndef CAN_FAULT_REGS_VH
`define CAN_FAULT_REGS_VH

`define OFS_ERR_COUNTERS 8'h00
`define OFS_EVENT_FLAGS 8'h04
`define OFS_EVENT_ENABLE 8'h08
`define OFS_EVENT_CODE 8'h0C
`define OFS_CONTROL 8'h10
`define OFS_BUF_FULL 8'h14
`define OFS_BUF_OVERFLOW 8'h18

`define FLG_TXBUF 0
`define FLG_RXBUF 1
`define FLG_OVF 2
`define FLG_FIFO 3
`define FLG_ERR 5
`define FLG_WAKE 6
`define FLG_INVALID 7
`define FLG_COMB_WARN 8
`define FLG_RX_WARN 9
`define FLG_TX_WARN 10
`define FLG_RX_PASSIVE 11
`define FLG_TX_PASSIVE 12
`define FLG_TX_BUSOFF 13
`define EVENT_MASK 8'hEF

`define LIM_WARN 9'h060
`define LIM_WARN_TOP 9'h07F
`define LIM_PASSIVE_STATE 9'h07F
`define LIM_PASSIVE_FLAG 9'h080
`define LIM_BUSOFF 9'h100
`define REC_RELOAD 8'h77
`define TEC_STEP 9'h008

`define CODE_OVF_BASE 7'h20
`define CODE_ERROR 7'h40
`define CODE_WAKE 7'h41
`define CODE_FIFO 7'h42
`define CODE_INVALID 7'h43
`define CODE_NONE 7'h44

`define CRC_POLY 15'h4599

`define ST_ACTIVE 2'h0
`define ST_PASSIVE 2'h1
`define ST_BUSOFF 2'h2

`endif

// file: test_can_fault_confine.sv
/* Self-checking bench of the confinement and event block.
   Assumes the flags clear by writing zero and a slave that may stretch. */
`timescale 1ns/1ns
`include "can_fault_regs.vh"
module test_can_fault_confine;
  reg ref_clk = 0, rst = 1, ce = 1, hsel = 0, hwrite = 0, othDom = 0, txBit = 1;
  reg bitValid = 0, isTransmitter = 0, inArbitration = 0, inAckSlot = 0, inFixedForm = 0;
  reg inLastEofBit = 0, inStuffedField = 0, sendingPassiveErr = 0, crcDataBit = 0;
  reg crcFieldBit = 0, crcCompare = 0, txSuccess = 0, rxSuccess = 0, busOffRecover = 0;
  reg txDone = 0, rxStore = 0, fifoNextToLastFull = 0;
  reg [31:0] haddr = 0, hwdata = 0, rd;
  reg [1:0] htrans = 0;
  reg [2:0] hsize = 3'h2, txDoneBuf = 0;
  reg [4:0] rxStoreBuf = 0;
  wire [31:0] hrdata;
  wire [1:0] errorState;
  wire hreadyout, hresp, rxBit, errFrameActive, errFramePassive, retransmitReq;
  wire hready = hreadyout;
  wire bus_receive_pin = rxBit;
  integer n_fail = 0, compares = 0, cyc = 0;
  can_fault_confine i_dut (.*);
  can_bus_node i_node (.*);
  // ****************
  // Tasks
  // ****************
  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      end_sim;
    end
  end
  task end_sim;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task reset;
    rst <= 1;
    repeat (12) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
  endtask
  task ahb(input w, input [7:0] a, input [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
  endtask
  // Field order: passive error, stuffed, arbitration, ack slot, fixed form, last EOF
  task bitc(input t, input tx, input dom, input [5:0] f);
    bitValid <= 1;
    isTransmitter <= t;
    txBit <= tx;
    othDom <= dom;
    {sendingPassiveErr, inStuffedField, inArbitration, inAckSlot, inFixedForm, inLastEofBit} <= f;
    @(posedge ref_clk);
    bitValid <= 0;
    othDom <= 0;
    {sendingPassiveErr, inStuffedField, inArbitration, inAckSlot, inFixedForm, inLastEofBit} <= 0;
    repeat (5) @(posedge ref_clk);
  endtask
  task pulse(input [2:0] k);
    {fifoNextToLastFull, rxStore, txDone} <= k;
    @(posedge ref_clk);
    {fifoNextToLastFull, rxStore, txDone} <= 0;
    repeat (2) @(posedge ref_clk);
  endtask
  // ****************
  // Scenarios
  // ****************
  task t_confine;
    ahb(0, `OFS_ERR_COUNTERS, 0);
    chk("counters", 0, rd[15:0]);
    bitc(1, 1, 1, 0);
    {txSuccess, rxSuccess} <= 2'h3;
    @(posedge ref_clk);
    {txSuccess, rxSuccess} <= 2'h0;
    ahb(0, `OFS_ERR_COUNTERS, 0);
    chk("tx counter", 16'h0700, rd[15:0]);
    repeat (12) bitc(1, 1, 1, 0);
    ahb(0, `OFS_EVENT_FLAGS, 0);
    chk("warning flags", 6'h05, rd[13:8]);
    chk("error flag", 1, rd[5]);
    ahb(1, `OFS_EVENT_ENABLE, 32'h00000020);
    ahb(0, `OFS_EVENT_CODE, 0);
    chk("error code", `CODE_ERROR, rd[6:0]);
    ahb(1, `OFS_EVENT_FLAGS, 0);
    ahb(0, `OFS_EVENT_FLAGS, 0);
    chk("sources kept", 6'h05, rd[13:8]);
    chk("error flag cleared", 0, rd[5]);
    repeat (4) bitc(1, 1, 1, 0);
    ahb(0, `OFS_EVENT_FLAGS, 0);
    chk("passive flags", 6'h11, rd[13:8]);
    chk("passive state", `ST_PASSIVE, errorState);
    repeat (16) bitc(1, 1, 1, 0);
    ahb(0, `OFS_EVENT_FLAGS, 0);
    chk("busoff flags", 6'h21, rd[13:8]);
    chk("busoff state", `ST_BUSOFF, errorState);
    busOffRecover <= 1;
    @(posedge ref_clk);
    busOffRecover <= 0;
    $display("confinement test done");
  endtask
  task t_excuse;
    bitc(1, 1, 1, 6'h18);
    bitc(1, 1, 1, 6'h20);
    bitc(1, 1, 1, 6'h04);
    bitc(0, 1, 1, 6'h03);
    ahb(0, `OFS_ERR_COUNTERS, 0);
    chk("excused counters", 0, rd[15:0]);
    bitc(1, 1, 0, 6'h04);
    bitc(0, 1, 1, 6'h02);
    ahb(0, `OFS_ERR_COUNTERS, 0);
    chk("ack and form", 16'h0801, rd[15:0]);
    ahb(0, `OFS_EVENT_FLAGS, 0);
    chk("invalid flag", 1, rd[7]);
    $display("exception test done");
  endtask
  task t_events;
    ahb(1, `OFS_EVENT_ENABLE, 32'h000000FF);
    txDoneBuf <= 3'h5;
    pulse(3'h1);
    ahb(0, `OFS_EVENT_CODE, 0);
    chk("tx code", 7'h05, rd[6:0]);
    ahb(1, `OFS_EVENT_FLAGS, 0);
    rxStoreBuf <= 5'h11;
    pulse(3'h2);
    ahb(0, `OFS_EVENT_CODE, 0);
    chk("rx code", 7'h11, rd[6:0]);
    ahb(0, `OFS_BUF_FULL, 0);
    chk("full bit", 1, rd[17]);
    ahb(1, `OFS_EVENT_FLAGS, 0);
    pulse(3'h2);
    ahb(0, `OFS_BUF_OVERFLOW, 0);
    chk("overflow bit", 1, rd[17]);
    ahb(0, `OFS_EVENT_FLAGS, 0);
    chk("overflow flag", 1, rd[2]);
    ahb(1, `OFS_EVENT_FLAGS, 0);
    pulse(3'h4);
    ahb(0, `OFS_EVENT_CODE, 0);
    chk("fifo code", `CODE_FIFO, rd[6:0]);
    ahb(1, `OFS_EVENT_ENABLE, 0);
    ahb(0, `OFS_EVENT_CODE, 0);
    chk("masked code", `CODE_NONE, rd[6:0]);
    ahb(1, `OFS_EVENT_ENABLE, 32'h00000040);
    ahb(1, `OFS_CONTROL, 32'h00000001);
    othDom <= 1;
    @(posedge ref_clk);
    othDom <= 0;
    ahb(0, `OFS_EVENT_CODE, 0);
    chk("wake code", `CODE_WAKE, rd[6:0]);
    $display("event test done");
  endtask
  initial begin
    reset;
    t_confine;
    reset;
    t_excuse;
    t_events;
    end_sim;
  end
endmodule
